// [hw/async_memory_strobe_ctrl.sv]
// Asynchronous memory strobe engine with port clock generation.
`timescale 1ns/1ps
// Summary of operation
// - Port clock from pin, CPU/4 or CPU/6
// - First output clock copies port clock edges
// - Divided clock by 1, 2 or 4
// - Phases counted in first output clock periods
// - Selects valid setup periods before strobe falls
// - Selects and data held after write strobe
// - Strobe edges launched on output clock rise
// - Read data captured as read strobe rises
// - Ready synchronised, sampled on clock rises
// - Ready only heeded in last two cycles
// - Low ready stretches strobe cycle by cycle
// - Strobe ends two cycles after ready high
// - Shared pins act only as strobes here
module async_memory_strobe_ctrl (
	input wire logic clock,
	input wire logic rst,
	input wire logic [1:0] clock_source_select,
	input wire logic [1:0] clock_divide_select,
	input wire logic memory_if_clock_in,
	input wire logic [async_mem_pkg::SPACES-1:0][async_mem_pkg::SETUP_W-1:0] read_setup_cycles,
	input wire logic [async_mem_pkg::SPACES-1:0][async_mem_pkg::STROBE_W-1:0] read_strobe_cycles,
	input wire logic [async_mem_pkg::SPACES-1:0][async_mem_pkg::HOLD_W-1:0] read_hold_cycles,
	input wire logic [async_mem_pkg::SPACES-1:0][async_mem_pkg::SETUP_W-1:0] write_setup_cycles,
	input wire logic [async_mem_pkg::SPACES-1:0][async_mem_pkg::STROBE_W-1:0] write_strobe_cycles,
	input wire logic [async_mem_pkg::SPACES-1:0][async_mem_pkg::HOLD_W-1:0] write_hold_cycles,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [1:0] req_space,
	input wire logic [async_mem_pkg::ADDR_W-1:0] req_addr,
	input wire logic [async_mem_pkg::LANES-1:0] req_lanes,
	input wire logic [async_mem_pkg::DATA_W-1:0] req_wdata,
	output logic req_ready,
	output logic done,
	output logic [async_mem_pkg::DATA_W-1:0] read_data,
	input wire logic async_ready_in,
	output logic memory_if_clock_out_a,
	output logic memory_if_clock_out_div,
	output logic [async_mem_pkg::SPACES-1:0] chip_select_n,
	output logic [async_mem_pkg::LANES-1:0] byte_lane_select_n,
	output logic [async_mem_pkg::ADDR_W-1:0] external_address_bus,
	input wire logic [async_mem_pkg::DATA_W-1:0] external_data_bus_in,
	output logic [async_mem_pkg::DATA_W-1:0] external_data_bus_out,
	output logic external_data_bus_oe,
	output logic async_output_enable_n,
	output logic async_read_strobe_n,
	output logic async_write_strobe_n
);
	import async_mem_pkg::*;

	// A programmed length of zero is treated as one period.
	function automatic logic [CNT_W-1:0] at_least_one(input logic [CNT_W-1:0] len);
		at_least_one = (len == '0) ? 6'h01 : len;
	endfunction

	// ------------------------------------------------------------
	// Port clock generation
	// ------------------------------------------------------------
	logic [2:0] cpu_cnt, next_cpu_cnt;
	logic next_clk_a, next_clk_div;
	logic [1:0] div_cnt, next_div_cnt;
	logic port_rise;

	always_comb begin
		next_cpu_cnt = cpu_cnt + 3'h1;
		next_clk_a = memory_if_clock_in;
		if (clock_source_select == SRC_CPU4) begin
			if (cpu_cnt >= CPU4_LAST) next_cpu_cnt = 3'h0;
			next_clk_a = (cpu_cnt < CPU4_HIGH);
		end else if (clock_source_select == SRC_CPU6) begin
			if (cpu_cnt >= CPU6_LAST) next_cpu_cnt = 3'h0;
			next_clk_a = (cpu_cnt < CPU6_HIGH);
		end
		port_rise = next_clk_a & ~memory_if_clock_out_a;
		next_div_cnt = port_rise ? div_cnt + 2'h1 : div_cnt;
		next_clk_div = memory_if_clock_out_div;
		if (clock_divide_select == DIV_2) begin
			if (port_rise) next_clk_div = ~memory_if_clock_out_div;
		end else if (clock_divide_select == DIV_4) begin
			if (port_rise && div_cnt[0]) next_clk_div = ~memory_if_clock_out_div;
		end else begin
			next_clk_div = next_clk_a;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cpu_cnt <= 3'h0;
			div_cnt <= 2'h0;
			memory_if_clock_out_a <= 1'b0;
			memory_if_clock_out_div <= 1'b0;
		end else begin
			cpu_cnt <= next_cpu_cnt;
			div_cnt <= next_div_cnt;
			memory_if_clock_out_a <= next_clk_a;
			memory_if_clock_out_div <= next_clk_div;
		end
	end

	// ------------------------------------------------------------
	// Ready synchroniser
	// ------------------------------------------------------------
	logic ready_meta, ready_sync;

	// The far end keeps each ready level for two periods or more.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ready_meta <= 1'b1;
			ready_sync <= 1'b1;
		end else begin
			ready_meta <= async_ready_in;
			ready_sync <= ready_meta;
		end
	end

	// ------------------------------------------------------------
	// Access sequencer
	// ------------------------------------------------------------
	state_e state, next_state;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic is_write, next_is_write;
	logic [1:0] space, next_space;
	logic seen_low, next_seen_low;
	logic released, next_released;
	logic [SPACES-1:0] next_cs_n;
	logic [LANES-1:0] next_lanes_n;
	logic [ADDR_W-1:0] next_addr;
	logic [DATA_W-1:0] next_wdata, next_rdata;
	logic next_oe_data, next_aoe_n, next_rd_n, next_wr_n, next_done, next_ready;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_is_write = is_write;
		next_space = space;
		next_seen_low = seen_low;
		next_released = released;
		next_cs_n = chip_select_n;
		next_lanes_n = byte_lane_select_n;
		next_addr = external_address_bus;
		next_wdata = external_data_bus_out;
		next_rdata = read_data;
		next_done = 1'b0;
		case (state)
			ST_IDLE: begin
				if (req_valid) begin
					next_state = ST_SETUP;
					next_is_write = req_write;
					next_space = req_space;
					next_cs_n = ~(4'h1 << req_space);
					next_lanes_n = ~req_lanes;
					next_addr = req_addr;
					next_wdata = req_wdata;
					next_cnt = at_least_one(req_write ?
						CNT_W'(write_setup_cycles[req_space]) :
						CNT_W'(read_setup_cycles[req_space])) + {5'h00, !port_rise};
				end
			end
			ST_SETUP: begin
				if (port_rise) begin
					if (cnt == 6'h01) begin
						next_state = ST_STROBE;
						next_seen_low = 1'b0;
						next_released = 1'b0;
						next_cnt = at_least_one(is_write ?
							CNT_W'(write_strobe_cycles[space]) :
							CNT_W'(read_strobe_cycles[space]));
					end else begin
						next_cnt = cnt - 6'h01;
					end
				end
			end
			ST_STROBE: begin
				if (port_rise) begin
					if (!released && cnt <= READY_WINDOW && !ready_sync) begin
						next_seen_low = 1'b1;
					end else if (seen_low && !released && ready_sync) begin
						next_released = 1'b1;
						next_cnt = READY_TAIL;
					end else if (cnt == 6'h01) begin
						next_state = ST_HOLD;
						if (!is_write) next_rdata = external_data_bus_in;
						next_cnt = at_least_one(is_write ?
							CNT_W'(write_hold_cycles[space]) :
							CNT_W'(read_hold_cycles[space]));
					end else begin
						next_cnt = cnt - 6'h01;
					end
				end
			end
			ST_HOLD: begin
				if (port_rise) begin
					if (cnt == 6'h01) begin
						next_state = ST_IDLE;
						next_cs_n = '1;
						next_lanes_n = '1;
						next_done = 1'b1;
					end else begin
						next_cnt = cnt - 6'h01;
					end
				end
			end
			default: next_state = ST_IDLE;
		endcase
		next_ready = (next_state == ST_IDLE);
		next_oe_data = (next_state != ST_IDLE) && next_is_write;
		next_aoe_n = !((next_state != ST_IDLE) && !next_is_write);
		next_rd_n = !(next_state == ST_STROBE && !next_is_write);
		next_wr_n = !(next_state == ST_STROBE && next_is_write);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			cnt <= '0;
			is_write <= 1'b0;
			space <= 2'h0;
			seen_low <= 1'b0;
			released <= 1'b0;
			chip_select_n <= '1;
			byte_lane_select_n <= '1;
			external_address_bus <= '0;
			external_data_bus_out <= '0;
			external_data_bus_oe <= 1'b0;
			read_data <= '0;
			async_output_enable_n <= 1'b1;
			async_read_strobe_n <= 1'b1;
			async_write_strobe_n <= 1'b1;
			done <= 1'b0;
			req_ready <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			is_write <= next_is_write;
			space <= next_space;
			seen_low <= next_seen_low;
			released <= next_released;
			chip_select_n <= next_cs_n;
			byte_lane_select_n <= next_lanes_n;
			external_address_bus <= next_addr;
			external_data_bus_out <= next_wdata;
			external_data_bus_oe <= next_oe_data;
			read_data <= next_rdata;
			async_output_enable_n <= next_aoe_n;
			async_read_strobe_n <= next_rd_n;
			async_write_strobe_n <= next_wr_n;
			done <= next_done;
			req_ready <= next_ready;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_cpu4_shape: assert property (@(posedge clock) disable iff (rst)
		($rose(memory_if_clock_out_a) && clock_source_select == SRC_CPU4 &&
		$past(clock_source_select) == SRC_CPU4 && $stable(clock_source_select))
		|-> memory_if_clock_out_a[*2] ##1 !memory_if_clock_out_a[*2] ##1 memory_if_clock_out_a)
		else $error("CPU/4 port clock shape wrong");
	a_pin_copy: assert property (@(posedge clock) disable iff (rst)
		(clock_source_select == SRC_PIN) |=> memory_if_clock_out_a == $past(memory_if_clock_in))
		else $error("Output clock does not follow pin clock");
	a_div2_toggle: assert property (@(posedge clock) disable iff (rst)
		($rose(memory_if_clock_out_a) && clock_divide_select == DIV_2 &&
		$past(clock_divide_select) == DIV_2) |-> $changed(memory_if_clock_out_div))
		else $error("Divided clock missed a toggle");
	a_strobe_on_rise: assert property (@(posedge clock) disable iff (rst)
		($changed(async_read_strobe_n) || $changed(async_write_strobe_n))
		|-> $rose(memory_if_clock_out_a))
		else $error("Strobe moved off a clock rise");
	a_select_before: assert property (@(posedge clock) disable iff (rst)
		$fell(async_read_strobe_n) |-> $past(chip_select_n) != '1 && !$past(async_output_enable_n))
		else $error("Selects not valid before read strobe");
	a_hold_after: assert property (@(posedge clock) disable iff (rst)
		$rose(async_write_strobe_n) |-> chip_select_n != '1 && external_data_bus_oe)
		else $error("Selects dropped with write strobe");
	a_strobe_phase: assert property (@(posedge clock) disable iff (rst)
		(!async_read_strobe_n || !async_write_strobe_n) |-> $past(next_state) == ST_STROBE)
		else $error("Strobe low outside strobe phase");
	a_ready_ignored: assert property (@(posedge clock) disable iff (rst)
		(state == ST_STROBE && port_rise && cnt > READY_WINDOW && !seen_low)
		|=> cnt == $past(cnt) - 6'h01)
		else $error("Ready heeded outside window");
	a_ready_stretch: assert property (@(posedge clock) disable iff (rst)
		(state == ST_STROBE && port_rise && cnt <= READY_WINDOW && !released && !ready_sync)
		|=> state == ST_STROBE && cnt == $past(cnt))
		else $error("Low ready did not stretch strobe");
	a_ready_release: assert property (@(posedge clock) disable iff (rst)
		(state == ST_STROBE && port_rise && seen_low && !released && ready_sync)
		|=> cnt == READY_TAIL && released)
		else $error("Strobe tail not two cycles");
	a_read_capture: assert property (@(posedge clock) disable iff (rst)
		(state == ST_STROBE && next_state == ST_HOLD && !is_write)
		|=> read_data == $past(external_data_bus_in))
		else $error("Read data not captured at strobe end");
endmodule

// [hw/async_mem_pkg.sv]
// Constants and types shared by the asynchronous memory strobe controller.
package async_mem_pkg;
	localparam int CLOCK_HZ = 20000000;
	localparam int SPACES = 4;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 32;
	localparam int LANES = 4;
	localparam int SETUP_W = 4;
	localparam int STROBE_W = 6;
	localparam int HOLD_W = 3;
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] READY_WINDOW = 6'h02;
	localparam logic [CNT_W-1:0] READY_TAIL = 6'h02;
	localparam logic [1:0] SRC_PIN = 2'h0;
	localparam logic [1:0] SRC_CPU4 = 2'h1;
	localparam logic [1:0] SRC_CPU6 = 2'h2;
	localparam logic [2:0] CPU4_LAST = 3'h3;
	localparam logic [2:0] CPU4_HIGH = 3'h2;
	localparam logic [2:0] CPU6_LAST = 3'h5;
	localparam logic [2:0] CPU6_HIGH = 3'h3;
	localparam logic [1:0] DIV_1 = 2'h0;
	localparam logic [1:0] DIV_2 = 2'h1;
	localparam logic [1:0] DIV_4 = 2'h2;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SETUP = 2'b01,
		ST_STROBE = 2'b10,
		ST_HOLD = 2'b11
	} state_e;
endpackage

// [tb/async_mem_model.sv]
// Asynchronous memory model that can stall a strobe through its ready line.
`timescale 1ns/1ps
module async_mem_model (
	input wire logic clock,
	input wire logic [3:0] chip_select_n,
	input wire logic [3:0] byte_lane_select_n,
	input wire logic [async_mem_pkg::ADDR_W-1:0] external_address_bus,
	input wire logic [async_mem_pkg::DATA_W-1:0] external_data_bus_out,
	input wire logic async_output_enable_n,
	input wire logic async_read_strobe_n,
	input wire logic async_write_strobe_n,
	input wire logic memory_if_clock_out_a,
	input wire logic [7:0] stall,
	output logic [async_mem_pkg::DATA_W-1:0] external_data_bus_in,
	output logic async_ready_in
);
	import async_mem_pkg::*;
	logic [DATA_W-1:0] mem [16];
	logic [DATA_W-1:0] last = '0;
	logic [7:0] cnt = 8'h00;
	logic pstr = 1'h1;
	logic pwe = 1'h1;
	logic pa = 1'h0;
	wire sel = chip_select_n != 4'hF;
	wire str = async_read_strobe_n & async_write_strobe_n;
	logic rdy = 1'h1;
	assign async_ready_in = rdy;
	// Released data lines show the inverse of the last word, so no stale value passes.
	assign external_data_bus_in = (sel && !async_output_enable_n) ?
		mem[external_address_bus[3:0]] : ~last;
	always @(negedge clock) begin
		pa <= memory_if_clock_out_a;
		pwe <= async_write_strobe_n;
		pstr <= str;
		if (sel && !async_output_enable_n)
			last <= external_data_bus_in;
		if (sel && async_write_strobe_n && !pwe)
			for (int b = 0; b < 4; b++)
				if (!byte_lane_select_n[b])
					mem[external_address_bus[3:0]][8*b +: 8] <= external_data_bus_out[8*b +: 8];
		if (pstr && !str && stall != 8'h00) begin
			rdy <= 1'h0;
			cnt <= stall;
		end else if (cnt != 8'h00)
			cnt <= cnt - 8'h01;
		else if (!rdy && memory_if_clock_out_a && !pa)
			rdy <= 1'h1;
	end
endmodule

// [tb/async_memory_strobe_ctrl_tb_top.sv]
// Self-checking bench for the asynchronous memory strobe engine.
`timescale 1ns/1ps
module async_memory_strobe_ctrl_tb_top;
	import async_mem_pkg::*;
	logic clock = 1'h0;
	logic rst = 1'h1;
	logic [1:0] clock_source_select = SRC_CPU4;
	logic [1:0] clock_divide_select = DIV_1;
	logic memory_if_clock_in = 1'h0;
	logic [SPACES-1:0][SETUP_W-1:0] read_setup_cycles, write_setup_cycles;
	logic [SPACES-1:0][STROBE_W-1:0] read_strobe_cycles, write_strobe_cycles;
	logic [SPACES-1:0][HOLD_W-1:0] read_hold_cycles, write_hold_cycles;
	logic req_valid = 1'h0;
	logic req_write = 1'h0;
	logic [1:0] req_space = 2'h0;
	logic [ADDR_W-1:0] req_addr = '0;
	logic [LANES-1:0] req_lanes = '0;
	logic [DATA_W-1:0] req_wdata = '0;
	logic req_ready, done, async_ready_in, memory_if_clock_out_a, memory_if_clock_out_div;
	logic external_data_bus_oe, async_output_enable_n, async_read_strobe_n, async_write_strobe_n;
	logic [DATA_W-1:0] read_data, external_data_bus_in, external_data_bus_out;
	logic [SPACES-1:0] chip_select_n;
	logic [LANES-1:0] byte_lane_select_n;
	logic [ADDR_W-1:0] external_address_bus;
	logic [7:0] stall = 8'h00;
	logic pa = 1'h0;
	logic pd = 1'h0;
	int bad_count = 0;
	int total_checks = 0;
	always #25 clock = ~clock;
	always begin
		repeat (4) @(negedge clock);
		memory_if_clock_in = ~memory_if_clock_in;
	end
	always @(negedge clock) begin
		pa <= memory_if_clock_out_a;
		pd <= memory_if_clock_out_div;
	end
	async_memory_strobe_ctrl async_memory_strobe_ctrl_i (.clock, .rst, .clock_source_select,
		.clock_divide_select, .memory_if_clock_in, .read_setup_cycles, .read_strobe_cycles,
		.read_hold_cycles, .write_setup_cycles, .write_strobe_cycles, .write_hold_cycles,
		.req_valid, .req_write, .req_space, .req_addr, .req_lanes, .req_wdata, .req_ready,
		.done, .read_data, .async_ready_in, .memory_if_clock_out_a, .memory_if_clock_out_div,
		.chip_select_n, .byte_lane_select_n, .external_address_bus, .external_data_bus_in,
		.external_data_bus_out, .external_data_bus_oe, .async_output_enable_n,
		.async_read_strobe_n, .async_write_strobe_n);
	async_mem_model async_mem_model_i (.clock, .chip_select_n, .byte_lane_select_n,
		.external_address_bus, .external_data_bus_out, .async_output_enable_n,
		.async_read_strobe_n, .async_write_strobe_n, .memory_if_clock_out_a, .stall,
		.external_data_bus_in, .async_ready_in);
	function automatic bit ck(input bit mismatch);
		total_checks++;
		return mismatch;
	endfunction
	task automatic fail(input string msg);
		bad_count++;
		$display("ERROR %0t %s", $time, msg);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_clocks();
		int ra, rd, ha, hd;
		logic [1:0] src [3] = '{SRC_PIN, SRC_CPU4, SRC_CPU6};
		logic [1:0] dv [3] = '{DIV_1, DIV_2, DIV_4};
		int per [3] = '{8, 4, 6};
		int dn [3] = '{1, 2, 4};
		for (int s = 0; s < 3; s++) begin
			for (int d = 0; d < 3; d++) begin
				clock_source_select = src[s];
				clock_divide_select = dv[d];
				repeat (96) @(negedge clock);
				ra = 0;
				rd = 0;
				ha = 0;
				hd = 0;
				repeat (96) begin
					@(negedge clock);
					ra += int'(memory_if_clock_out_a && !pa);
					rd += int'(memory_if_clock_out_div && !pd);
					ha += int'(memory_if_clock_out_a);
					hd += int'(memory_if_clock_out_div);
				end
				if (ck(ra != 96 / per[s])) fail("port clock period");
				if (ck(ha != 48)) fail("port clock high phase");
				if (ck(rd != 96 / (per[s] * dn[d]) || hd != 48)) fail("divided clock");
			end
		end
		$display("clock test done");
	endtask
	task automatic access(input bit wr, input logic [1:0] sp, input logic [ADDR_W-1:0] ad,
			input logic [LANES-1:0] ln, input logic [DATA_W-1:0] wd, input int su,
			input int stb, input int ho, input int after);
		int cnt [3] = '{0, 0, 0};
		int ph = 0;
		int ra = 0;
		int n;
		int t0 = 0;
		bit al;
		bit pcs = 1'h1;
		bit low = 1'h0;
		bit sel_bad = 1'h0;
		bit edge_bad = 1'h0;
		logic pstr = 1'h1;
		logic str;
		for (n = 0; n < 50 && req_ready !== 1'h1; n++) @(negedge clock);
		if (req_ready !== 1'h1) begin
			fail("request never accepted");
			results();
		end
		req_valid = 1'h1;
		req_write = wr;
		req_space = sp;
		req_addr = ad;
		req_lanes = ln;
		req_wdata = wd;
		@(negedge clock);
		req_valid = 1'h0;
		al = memory_if_clock_out_a && !pa;
		for (n = 0; n < 3000; n++) begin
			@(negedge clock);
			str = wr ? async_write_strobe_n : async_read_strobe_n;
			if (ph == 0)
				t0++;
			if (memory_if_clock_out_a && !pa && pcs) begin
				cnt[ph]++;
				if (ph == 1 && low && async_ready_in)
					ra++;
			end
			if (str !== pstr) begin
				edge_bad |= !(memory_if_clock_out_a && !pa);
				if (ph < 2)
					ph++;
			end
			if (ph == 1 && !async_ready_in)
				low = 1'h1;
			pstr = str;
			pcs = chip_select_n != 4'hF;
			if (pcs && (chip_select_n !== ~(4'h1 << sp) || byte_lane_select_n !== ~ln
					|| external_address_bus !== ad || async_output_enable_n !== wr
					|| external_data_bus_oe !== wr || (wr && external_data_bus_out !== wd)
					|| (wr ? async_read_strobe_n : async_write_strobe_n) !== 1'h1))
				sel_bad = 1'h1;
			if (done === 1'h1)
				break;
		end
		if (n == 3000) begin
			fail("access never finished");
			results();
		end
		if (ck(cnt[0] != su + int'(!al) || t0 < 4 * su)) fail("setup length");
		if (ck(after == 0 ? cnt[1] != stb : (cnt[1] <= stb || ra != after))) fail("strobe");
		if (ck(cnt[2] != ho)) fail("hold length");
		if (ck(edge_bad)) fail("strobe edge off port clock rise");
		if (ck(sel_bad)) fail("select group changed");
		if (ck(ph != 2 || chip_select_n !== 4'hF || str !== 1'h1)) fail("not released");
	endtask
	task automatic test_spaces();
		clock_source_select = SRC_CPU4;
		clock_divide_select = DIV_2;
		repeat (24) @(negedge clock);
		for (int s = 0; s < 4; s++) begin
			access(1'h1, 2'(s), ADDR_W'(s), 4'hF, {8{4'(s + 9)}}, s + 2, s + 3,
				(s == 3) ? 1 : 3 - s, 0);
			access(1'h0, 2'(s), ADDR_W'(s), 4'hF, '0, s + 1, s + 2, s + 1, 0);
			if (ck(read_data !== {8{4'(s + 9)}})) fail("read back");
		end
		access(1'h1, 2'h0, ADDR_W'(1), 4'h5, 32'h1234_5678, 2, 3, 3, 0);
		access(1'h0, 2'h0, ADDR_W'(1), 4'hF, '0, 1, 2, 1, 0);
		if (ck(read_data !== 32'hAA34_AA78)) fail("lane merge");
		$display("space test done");
	endtask
	task automatic test_ready();
		stall = 8'h08;
		access(1'h1, 2'h3, ADDR_W'(9), 4'hF, 32'h0F0F_0F0F, 5, 6, 1, 0);
		stall = 8'h28;
		access(1'h0, 2'h1, ADDR_W'(9), 4'hF, '0, 2, 3, 2, 3);
		if (ck(read_data !== 32'h0F0F_0F0F)) fail("stretched read data");
		stall = 8'h00;
		$display("ready test done");
	endtask
	initial begin
		for (int s = 0; s < SPACES; s++) begin
			read_setup_cycles[s] = SETUP_W'(s + 1);
			read_strobe_cycles[s] = STROBE_W'(s + 2);
			read_hold_cycles[s] = HOLD_W'(s + 1);
			write_setup_cycles[s] = SETUP_W'(s + 2);
			write_strobe_cycles[s] = STROBE_W'(s + 3);
			write_hold_cycles[s] = HOLD_W'(3 - s);
		end
		repeat (10) @(negedge clock);
		if (ck(chip_select_n !== 4'hF || req_ready !== 1'h0)) fail("reset state");
		rst = 1'h0;
		test_clocks();
		test_spaces();
		test_ready();
		results();
	end
endmodule
